// ---- design/cfgsp_fifo.v ----
// Synchronous first-word-fall-through FIFO with valid/ready on both sides.
// Assumes one clock for both sides; depth is a power of two.
`timescale 1ns/1ns
`default_nettype none

module cfgsp_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 32
) (
	// clock and reset
	input  wire             clk_i,
	input  wire             rst_n_i,
	// filling side
	input  wire             wr_valid_i,
	input  wire [WIDTH-1:0] wr_data_i,
	output wire             wr_ready_o,
	// draining side
	output wire             rd_valid_o,
	output wire [WIDTH-1:0] rd_data_o,
	input  wire             rd_ready_i
);

	localparam AW = $clog2(DEPTH);
	localparam [AW:0] FULL_CNT = DEPTH;

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_q;
	reg [AW-1:0]    rd_ptr_q;
	reg [AW:0]      count_q;

	wire push = wr_valid_i & wr_ready_o;
	wire pop  = rd_valid_o & rd_ready_i;

	assign wr_ready_o = (count_q != FULL_CNT);
	assign rd_valid_o = (count_q != {(AW+1){1'b0}});
	assign rd_data_o  = mem_q[rd_ptr_q];

	always @(posedge clk_i) begin
		if (push) begin
			mem_q[wr_ptr_q] <= wr_data_i;
		end
	end

	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				wr_ptr_q <= wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				count_q <= count_q + 1'b1;
			end else if (pop && !push) begin
				count_q <= count_q - 1'b1;
			end
		end
	end

endmodule

`default_nettype wire

// ---- design/cfgsp_map.vh ----
// Constants for the configurable-pin serial port: frame and word sizes,
// pin function codes, buffering depth and host clock limits.
// Assumes it is included by bare name from each design file that needs it.
`ifndef CFGSP_MAP_VH
`define CFGSP_MAP_VH

// frame and word layout
`define CFGSP_WORD_W        16
`define CFGSP_FRAME_BITS    5'h10
`define CFGSP_LAST_BIT      5'h0f
`define CFGSP_CNT_W         5
`define CFGSP_MSB           15

// reset values
`define CFGSP_IDLE_WORD     16'h0000
`define CFGSP_CNT_RST       5'h00

// buffering
`define CFGSP_FIFO_DEPTH    32

// pins and per-pin function codes, two bits per pin
`define CFGSP_PIN_COUNT     8
`define CFGSP_BUSY_PIN      7
`define CFGSP_MODE_DAC      2'h0
`define CFGSP_MODE_ADC      2'h1
`define CFGSP_MODE_DIN      2'h2
`define CFGSP_MODE_DOUT     2'h3

// synchroniser depth for everything arriving from pins
`define CFGSP_SYNC_STAGES   2

// clock rates in MHz: local clock and the host limits on the serial clock
`define CFGSP_MCLK_MHZ      50
`define CFGSP_SCLK_WR_MHZ   50
`define CFGSP_SCLK_RD_MHZ   20

`endif

// ---- design/cfgsp_sync.v ----
// Multi-bit two-stage level synchroniser into the local clock domain.
// Assumes each bit is an independent level; no word coherency is promised.
`timescale 1ns/1ns
`default_nettype none

module cfgsp_sync #(
	parameter WIDTH = 1
) (
	// clock and reset
	input  wire             clk_i,
	input  wire             rst_n_i,
	// asynchronous in, synchronised out
	input  wire [WIDTH-1:0] d_i,
	output wire [WIDTH-1:0] q_o
);

	reg [WIDTH-1:0] meta_q;
	reg [WIDTH-1:0] sync_q;

	// the first stage feeds the second stage only
	always @(posedge clk_i) begin
		if (!rst_n_i) begin
			meta_q <= {WIDTH{1'b0}};
			sync_q <= {WIDTH{1'b0}};
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;

endmodule

`default_nettype wire

// ---- design/cfgsp_top.v ----
// Serial slave port and pin-function logic of the configurable converter/GPIO device.
// Assumes all link and pin inputs are asynchronous and oversampled by mclk_i;
// converter, readback and temperature words come from same-clock logic.
`timescale 1ns/1ns
`default_nettype none
`include "cfgsp_map.vh"

module cfgsp_top (
	// clock and reset
	input  wire        mclk_i,
	input  wire        rst_n_i,
	// serial link pins
	input  wire        sync_n_i,
	input  wire        sclk_i,
	input  wire        serial_in_line_i,
	output wire        serial_out_line_o,
	// received words towards the register logic
	output wire [15:0] rx_data_o,
	output wire        rx_valid_o,
	input  wire        rx_ready_i,
	output wire        rx_overrun_o,
	output wire        frame_abort_o,
	// outgoing word sources
	input  wire [15:0] adc_data_i,
	input  wire        adc_valid_i,
	output wire        adc_ack_o,
	input  wire [15:0] rdbk_data_i,
	input  wire        rdbk_valid_i,
	output wire        rdbk_ack_o,
	input  wire [15:0] temp_data_i,
	input  wire        temp_valid_i,
	output wire        temp_ack_o,
	// pin configuration and data from the register logic
	input  wire [15:0] pin_mode_i,
	input  wire [7:0]  gpio_out_i,
	input  wire        busy_on_pin8_i,
	input  wire        adc_busy_i,
	// configurable pins
	input  wire [6:0]  config_pins_low_seven_i,
	output wire [6:0]  config_pins_low_seven_o,
	output wire [6:0]  config_pins_low_seven_oe_o,
	input  wire        config_pin_eight_i,
	output wire        config_pin_eight_o,
	output wire        config_pin_eight_oe_o,
	// per-pin function enables and sampled digital inputs
	output wire [7:0]  dac_en_o,
	output wire [7:0]  adc_en_o,
	output wire [7:0]  gpio_in_o
);

	localparam [2:0] ST_IDLE  = 3'h1;
	localparam [2:0] ST_SHIFT = 3'h2;
	localparam [2:0] ST_DONE  = 3'h4;

	////////////////////////////////////////////////////////////////////////////////
	// synchronisers

	wire       cs_n_s;
	wire       sclk_s;
	wire       sdi_s;
	wire [7:0] pin_s;

	cfgsp_sync #(
		.WIDTH (3)
	) u_link_sync (
		.clk_i   (mclk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({sync_n_i, sclk_i, serial_in_line_i}),
		.q_o     ({cs_n_s, sclk_s, sdi_s})
	);

	cfgsp_sync #(
		.WIDTH (`CFGSP_PIN_COUNT)
	) u_pin_sync (
		.clk_i   (mclk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({config_pin_eight_i, config_pins_low_seven_i}),
		.q_o     (pin_s)
	);

	////////////////////////////////////////////////////////////////////////////////
	// edge detection on the sampled link

	reg cs_n_prev_q;
	reg sclk_prev_q;

	wire cs_fall  = cs_n_prev_q & ~cs_n_s;
	wire cs_rise  = ~cs_n_prev_q & cs_n_s;
	wire sck_fall = sclk_prev_q & ~sclk_s;
	wire sck_rise = ~sclk_prev_q & sclk_s;

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			// the synchroniser resets to 0, so match it here to avoid a false select fall
			cs_n_prev_q <= 1'b0;
			sclk_prev_q <= 1'b0;
		end else begin
			cs_n_prev_q <= cs_n_s;
			sclk_prev_q <= sclk_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outgoing word holding register

	reg        hold_q;
	reg [15:0] hold_data_q;
	reg        adc_ack_q;
	reg        rdbk_ack_q;
	reg        temp_ack_q;
	reg [2:0]  state_q;
	reg [2:0]  state_d;

	wire        take_hold = cs_fall & state_q[0];
	wire [15:0] load_word = hold_q ? hold_data_q : `CFGSP_IDLE_WORD;

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			hold_q      <= 1'b0;
			hold_data_q <= `CFGSP_IDLE_WORD;
			adc_ack_q   <= 1'b0;
			rdbk_ack_q  <= 1'b0;
			temp_ack_q  <= 1'b0;
		end else begin
			adc_ack_q  <= 1'b0;
			rdbk_ack_q <= 1'b0;
			temp_ack_q <= 1'b0;
			// the held word is taken for shifting only at a select fall in idle, so the output stays coherent
			if (take_hold) begin
				hold_q <= 1'b0;
			end else if (!hold_q && !adc_ack_q && !rdbk_ack_q && !temp_ack_q) begin
				if (adc_valid_i) begin
					hold_q      <= 1'b1;
					hold_data_q <= adc_data_i;
					adc_ack_q   <= 1'b1;
				end else if (rdbk_valid_i) begin
					hold_q      <= 1'b1;
					hold_data_q <= rdbk_data_i;
					rdbk_ack_q  <= 1'b1;
				end else if (temp_valid_i) begin
					hold_q      <= 1'b1;
					hold_data_q <= temp_data_i;
					temp_ack_q  <= 1'b1;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// frame state machine

	reg [4:0]  bit_cnt_q;
	reg [15:0] rx_sh_q;
	reg [15:0] tx_sh_q;
	reg        sdo_q;
	reg        fell_q;
	reg        done_q;
	reg        abort_q;

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (cs_fall) begin
					state_d = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (cs_rise) begin
					state_d = ST_IDLE;
				end else if (sck_fall && bit_cnt_q == `CFGSP_LAST_BIT) begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				if (cs_rise) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_q   <= ST_IDLE;
			bit_cnt_q <= `CFGSP_CNT_RST;
			rx_sh_q   <= `CFGSP_IDLE_WORD;
			tx_sh_q   <= `CFGSP_IDLE_WORD;
			sdo_q     <= 1'b0;
			fell_q    <= 1'b0;
			done_q    <= 1'b0;
			abort_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			done_q  <= 1'b0;
			abort_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					bit_cnt_q <= `CFGSP_CNT_RST;
					fell_q    <= 1'b0;
					if (cs_fall) begin
						sdo_q   <= load_word[`CFGSP_MSB];
						tx_sh_q <= {load_word[14:0], 1'b0};
					end
				end
				ST_SHIFT: begin
					if (cs_rise) begin
						abort_q <= 1'b1;
						sdo_q   <= 1'b0;
					end else if (sck_fall) begin
						bit_cnt_q <= bit_cnt_q + 1'b1;
						rx_sh_q   <= {rx_sh_q[14:0], sdi_s};
						fell_q    <= 1'b1;
						if (bit_cnt_q == `CFGSP_LAST_BIT) begin
							done_q <= 1'b1;
						end
					end else if (sck_rise && fell_q) begin
						sdo_q   <= tx_sh_q[`CFGSP_MSB];
						tx_sh_q <= {tx_sh_q[14:0], 1'b0};
						fell_q  <= 1'b0;
					end
				end
				ST_DONE: begin
					if (cs_rise) begin
						sdo_q <= 1'b0;
					end else if (sck_rise && fell_q) begin
						sdo_q   <= tx_sh_q[`CFGSP_MSB];
						tx_sh_q <= {tx_sh_q[14:0], 1'b0};
						fell_q  <= 1'b0;
					end
				end
				default: begin
					sdo_q <= 1'b0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// received word staging and buffering

	reg        pend_q;
	reg [15:0] pend_data_q;
	reg        overrun_q;
	wire       fifo_wr_ready;
	wire       fifo_rd_valid;
	wire [15:0] fifo_rd_data;
	reg        rx_valid_q;
	reg [15:0] rx_data_q;

	wire fifo_pop = fifo_rd_valid & (~rx_valid_q | rx_ready_i);

	// a full fifo stalls the staging word; only a second finished frame overruns
	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pend_q      <= 1'b0;
			pend_data_q <= `CFGSP_IDLE_WORD;
			overrun_q   <= 1'b0;
		end else begin
			overrun_q <= 1'b0;
			if (done_q && (!pend_q || fifo_wr_ready)) begin
				pend_q      <= 1'b1;
				pend_data_q <= rx_sh_q;
			end else if (done_q) begin
				overrun_q <= 1'b1;
			end else if (pend_q && fifo_wr_ready) begin
				pend_q <= 1'b0;
			end
		end
	end

	cfgsp_fifo #(
		.WIDTH (`CFGSP_WORD_W),
		.DEPTH (`CFGSP_FIFO_DEPTH)
	) u_rx_fifo (
		.clk_i      (mclk_i),
		.rst_n_i    (rst_n_i),
		.wr_valid_i (pend_q),
		.wr_data_i  (pend_data_q),
		.wr_ready_o (fifo_wr_ready),
		.rd_valid_o (fifo_rd_valid),
		.rd_data_o  (fifo_rd_data),
		.rd_ready_i (fifo_pop)
	);

	always @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rx_valid_q <= 1'b0;
			rx_data_q  <= `CFGSP_IDLE_WORD;
		end else if (fifo_pop) begin
			rx_valid_q <= 1'b1;
			rx_data_q  <= fifo_rd_data;
		end else if (rx_ready_i) begin
			rx_valid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// per-pin function selection

	reg [7:0] pin_out_q;
	reg [7:0] pin_oe_q;
	reg [7:0] dac_en_q;
	reg [7:0] adc_en_q;
	reg [7:0] gpio_in_q;

	genvar gi;
	generate
		for (gi = 0; gi < `CFGSP_PIN_COUNT; gi = gi + 1) begin : g_pin
			wire [1:0] mode = pin_mode_i[2*gi+1:2*gi];
			wire       busy = (gi == `CFGSP_BUSY_PIN) && busy_on_pin8_i;
			always @(posedge mclk_i) begin
				if (!rst_n_i) begin
					pin_out_q[gi] <= 1'b0;
					pin_oe_q[gi]  <= 1'b0;
					dac_en_q[gi]  <= 1'b0;
					adc_en_q[gi]  <= 1'b0;
					gpio_in_q[gi] <= 1'b0;
				end else begin
					pin_out_q[gi] <= busy ? adc_busy_i : gpio_out_i[gi];
					pin_oe_q[gi]  <= busy | (mode == `CFGSP_MODE_DOUT);
					dac_en_q[gi]  <= ~busy & (mode == `CFGSP_MODE_DAC);
					adc_en_q[gi]  <= ~busy & (mode == `CFGSP_MODE_ADC);
					gpio_in_q[gi] <= ~busy & (mode == `CFGSP_MODE_DIN) & pin_s[gi];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign serial_out_line_o          = sdo_q;
	assign rx_data_o                  = rx_data_q;
	assign rx_valid_o                 = rx_valid_q;
	assign rx_overrun_o               = overrun_q;
	assign frame_abort_o              = abort_q;
	assign adc_ack_o                  = adc_ack_q;
	assign rdbk_ack_o                 = rdbk_ack_q;
	assign temp_ack_o                 = temp_ack_q;
	assign config_pins_low_seven_o    = pin_out_q[6:0];
	assign config_pins_low_seven_oe_o = pin_oe_q[6:0];
	assign config_pin_eight_o         = pin_out_q[7];
	assign config_pin_eight_oe_o      = pin_oe_q[7];
	assign dac_en_o                   = dac_en_q;
	assign adc_en_o                   = adc_en_q;
	assign gpio_in_o                  = gpio_in_q;

endmodule

`default_nettype wire

// ---- verif/cfgsp_host.sv ----
// Host serial master model: frame select, serial clock and data in, captures data out.
// Assumes the local clock only paces it; link edges are unrelated to the device sampling.
`timescale 1ns/1ns
`default_nettype none

module cfgsp_host (
	input  wire logic mclk_i,
	output var  logic sync_n_o,
	output var  logic sclk_o,
	output var  logic sdi_o,
	input  wire logic sdo_i
);
	initial begin
		sync_n_o = 1'b1;
		sclk_o   = 1'b0;
		sdi_o    = 1'b0;
	end

	task automatic gap(input int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask

	task automatic xfer(input logic [15:0] w, input int nfall, input logic cpol,
		output logic [15:0] got);
		got = 16'h0000;
		gap(1);
		sclk_o = cpol;
		gap(4);
		sync_n_o = 1'b0;
		for (int i = 0; i < nfall; i++) begin
			gap(4);
			sclk_o = 1'b1;
			sdi_o  = (i < 16) ? w[15 - i] : ~sdi_o;
			gap(4);
			if (i < 16)
				got[15 - i] = sdo_i;
			sclk_o = 1'b0;
		end
		gap(4);
		sclk_o = cpol;
		gap(4);
		sync_n_o = 1'b1;
		// released line must not keep its last value
		sdi_o = ~sdi_o;
		gap(4);
	endtask
endmodule
`default_nettype wire

// ---- verif/cfgsp_top_monitor.sv ----
// Checker for the serial port top: pulse widths, stream hold, output timing, pin functions.
// Assumes it is bound into the top module and sees its ports only.
`timescale 1ns/1ns
`default_nettype none
`include "cfgsp_map.vh"

module cfgsp_top_monitor (
	// clock and reset
	input wire logic        mclk_i,
	input wire logic        rst_n_i,
	// link
	input wire logic        sync_n_i,
	input wire logic        sclk_i,
	input wire logic        serial_out_line_o,
	// word streams
	input wire logic [15:0] rx_data_o,
	input wire logic        rx_valid_o,
	input wire logic        rx_ready_i,
	input wire logic        frame_abort_o,
	input wire logic        adc_ack_o,
	input wire logic        rdbk_ack_o,
	input wire logic        temp_ack_o,
	// pins
	input wire logic [15:0] pin_mode_i,
	input wire logic [7:0]  gpio_out_i,
	input wire logic        busy_on_pin8_i,
	input wire logic        adc_busy_i,
	input wire logic [6:0]  config_pins_low_seven_o,
	input wire logic [6:0]  config_pins_low_seven_oe_o,
	input wire logic        config_pin_eight_o,
	input wire logic        config_pin_eight_oe_o,
	input wire logic        config_pin_eight_i,
	input wire logic [6:0]  config_pins_low_seven_i,
	input wire logic [7:0]  dac_en_o,
	input wire logic [7:0]  adc_en_o,
	input wire logic [7:0]  gpio_in_o
);
	logic [6:0] dac_exp;
	logic [6:0] dout_exp;
	logic [7:0] adc_exp;
	logic [7:0] din_exp;
	logic [7:0] pins_in;
	logic       dac8_exp;
	logic       dout8_exp;
	logic [3:0] quiet_q;
	logic       sclk_p_q;
	logic       sync_p_q;

	always_comb
		for (int i = 0; i < 7; i++) begin
			dac_exp[i]  = pin_mode_i[2*i +: 2] == `CFGSP_MODE_DAC;
			dout_exp[i] = pin_mode_i[2*i +: 2] == `CFGSP_MODE_DOUT;
		end

	// pin eight loses its own function while it carries busy
	assign pins_in = {config_pin_eight_i, config_pins_low_seven_i};
	always_comb begin
		dac8_exp  = pin_mode_i[15:14] == `CFGSP_MODE_DAC;
		dout8_exp = pin_mode_i[15:14] == `CFGSP_MODE_DOUT;
		for (int i = 0; i < 8; i++) begin
			adc_exp[i] = pin_mode_i[2*i +: 2] == `CFGSP_MODE_ADC && !(i == 7 && busy_on_pin8_i);
			din_exp[i] = pin_mode_i[2*i +: 2] == `CFGSP_MODE_DIN && !(i == 7 && busy_on_pin8_i);
		end
	end

	// cycles since the link pins last moved; the output may only move shortly after
	always_ff @(posedge mclk_i) begin
		sclk_p_q <= sclk_i;
		sync_p_q <= sync_n_i;
		if (!rst_n_i || sclk_i != sclk_p_q || sync_n_i != sync_p_q)
			quiet_q <= 4'h0;
		else if (quiet_q != 4'hf)
			quiet_q <= quiet_q + 4'h1;
	end

	////////////////////////////////////////
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);

	sequence sel_idle;
		sync_n_i [*4];
	endsequence
	sequence rx_stall;
		rx_valid_o && !rx_ready_i;
	endsequence

	chk_abort_pulse: assert property (frame_abort_o |=> !frame_abort_o)
		else $error("abort pulse too long");
	chk_rx_hold: assert property (rx_stall |=> rx_valid_o && $stable(rx_data_o))
		else $error("received word not held");
	chk_ack_single: assert property ($onehot0({adc_ack_o, rdbk_ack_o, temp_ack_o}))
		else $error("two sources taken at once");
	chk_ack_pulse: assert property (|{adc_ack_o, rdbk_ack_o, temp_ack_o} |=>
		!(|{adc_ack_o, rdbk_ack_o, temp_ack_o}))
		else $error("source taken twice in a row");
	chk_sdo_idle: assert property (sel_idle |-> !serial_out_line_o)
		else $error("output line active outside frame");
	chk_sdo_timing: assert property ($changed(serial_out_line_o) |-> quiet_q <= 4'h3)
		else $error("output line moved without a link edge");
	chk_pin_dac: assert property ($past(rst_n_i) |=> dac_en_o[6:0] == $past(dac_exp))
		else $error("analog output enable wrong");
	chk_pin_dout: assert property ($past(rst_n_i) |=> config_pins_low_seven_oe_o ==
		$past(dout_exp) && (config_pins_low_seven_o & config_pins_low_seven_oe_o) ==
		(7'($past(gpio_out_i)) & $past(dout_exp)))
		else $error("digital output drive wrong");
	chk_busy_pin: assert property ($past(rst_n_i) && busy_on_pin8_i |=>
		config_pin_eight_oe_o && config_pin_eight_o == $past(adc_busy_i) && !dac_en_o[7])
		else $error("busy pin not driven");
	chk_pin_adc: assert property ($past(rst_n_i) |=> adc_en_o == $past(adc_exp))
		else $error("analog input enable wrong");
	chk_pin_din: assert property ($past(rst_n_i, 2) |=>
		gpio_in_o == ($past(din_exp) & $past(pins_in, 3)))
		else $error("digital input level wrong");
	chk_pin8_plain: assert property ($past(rst_n_i) && !busy_on_pin8_i |=>
		config_pin_eight_oe_o == $past(dout8_exp) && dac_en_o[7] == $past(dac8_exp) &&
		config_pin_eight_o == $past(gpio_out_i[7]))
		else $error("eighth pin function wrong");
endmodule

bind cfgsp_top cfgsp_top_monitor u_mon (.mclk_i, .rst_n_i, .sync_n_i, .sclk_i,
	.serial_out_line_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .frame_abort_o, .adc_ack_o,
	.rdbk_ack_o, .temp_ack_o, .pin_mode_i, .gpio_out_i, .busy_on_pin8_i, .adc_busy_i,
	.config_pins_low_seven_o, .config_pins_low_seven_oe_o, .config_pin_eight_o,
	.config_pin_eight_oe_o, .dac_en_o, .config_pin_eight_i, .config_pins_low_seven_i,
	.adc_en_o, .gpio_in_o);
`default_nettype wire

// ---- verif/tb_cfgsp_top.sv ----
// Self-checking bench for the serial port top: host frames, word streams, pin functions.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none

module tb_cfgsp_top;
	logic        mclk_i;
	logic        rst_n_i = 1'b0;
	logic        rx_ready_i = 1'b1;
	logic        adc_valid_i = 1'b0;
	logic        rdbk_valid_i = 1'b0;
	logic        temp_valid_i = 1'b0;
	logic        rand_rdy = 1'b1;
	logic        sync_n_i, sclk_i, serial_in_line_i, serial_out_line_o, rx_valid_o;
	logic        rx_overrun_o, frame_abort_o, adc_ack_o, rdbk_ack_o, temp_ack_o;
	logic        busy_on_pin8_i, adc_busy_i, config_pin_eight_i;
	logic [15:0] rx_data_o, adc_data_i, rdbk_data_i, temp_data_i, pin_mode_i, got;
	logic [7:0]  gpio_out_i;
	logic [6:0]  config_pins_low_seven_i;
	logic [15:0] rxq[$];
	logic [15:0] sdoq[$];
	int          error_cnt = 0, checks_done = 0, seed = 6302, aborts = 0, ovrs = 0, cyc = 0;
	event        frame_done;

	cfgsp_host u_host (.mclk_i, .sync_n_o(sync_n_i), .sclk_o(sclk_i),
		.sdi_o(serial_in_line_i), .sdo_i(serial_out_line_o));

	cfgsp_top DUT (.mclk_i, .rst_n_i, .sync_n_i, .sclk_i, .serial_in_line_i,
		.serial_out_line_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .rx_overrun_o,
		.frame_abort_o, .adc_data_i, .adc_valid_i, .adc_ack_o, .rdbk_data_i, .rdbk_valid_i,
		.rdbk_ack_o, .temp_data_i, .temp_valid_i, .temp_ack_o, .pin_mode_i, .gpio_out_i,
		.busy_on_pin8_i, .adc_busy_i, .config_pins_low_seven_i, .config_pins_low_seven_o(),
		.config_pins_low_seven_oe_o(), .config_pin_eight_i, .config_pin_eight_o(),
		.config_pin_eight_oe_o(), .dac_en_o(), .adc_en_o(), .gpio_in_o());

	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end

	////////////////////////////////////////
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] act);
		checks_done++;
		if (act !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, act);
		end
	endtask

	task automatic conclude;
		if (error_cnt == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// pin controls are random throughout so the checker sees every mode
	task automatic shake;
		{pin_mode_i, gpio_out_i, config_pins_low_seven_i, config_pin_eight_i, busy_on_pin8_i,
			adc_busy_i} = 34'({$random(seed), $random(seed)});
	endtask

	task automatic frame(input logic [15:0] exp, input int nfall, input logic cpol);
		logic [15:0] w;
		w = 16'($random(seed));
		if (nfall >= 16) begin
			rxq.push_back(w);
			sdoq.push_back(exp);
		end
		u_host.xfer(w, nfall, cpol, got);
		if (nfall >= 16)
			-> frame_done;
	endtask

	always @(posedge mclk_i) begin
		#1;
		shake();
		if (rand_rdy)
			rx_ready_i = 1'($random(seed));
	end

	always @(frame_done)
		check("serial_out", sdoq.pop_front(), got);

	// ceiling: the frames and draining need about 6000 cycles, the rest is margin
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 30000) begin
			error_cnt++;
			conclude();
		end
	end

	always @(posedge mclk_i) begin
		if (adc_ack_o)
			adc_valid_i <= 1'b0;
		if (rdbk_ack_o)
			rdbk_valid_i <= 1'b0;
		if (temp_ack_o)
			temp_valid_i <= 1'b0;
		if (frame_abort_o)
			aborts++;
		// a dropped word is always the newest one
		if (rx_overrun_o) begin
			ovrs++;
			void'(rxq.pop_back());
		end
		if (rx_valid_o && rx_ready_i)
			check("rx_data", rxq.size() ? rxq.pop_front() : 16'hxxxx, rx_data_o);
	end

	initial begin
		shake();
		{adc_data_i, rdbk_data_i, temp_data_i} = 48'({$random(seed), $random(seed)});
		repeat (2) @(posedge mclk_i);
		#1 rst_n_i = 1'b1;
		repeat (3) @(posedge mclk_i);
		#1 {adc_valid_i, rdbk_valid_i, temp_valid_i} = 3'h7;
		for (int k = 0; k < 20 && adc_valid_i; k++)
			@(negedge mclk_i);
		check("adc_taken", 16'h0000, {15'h0000, adc_valid_i});
		frame(adc_data_i, 16, 1'b0);
		frame(rdbk_data_i, 16, 1'b1);
		frame(temp_data_i, 18, 1'b0);
		frame(16'h0000, 16, 1'b1);
		frame(16'h0000, 5, 1'b0);
		frame(16'h0000, 16, 1'b1);
		check("aborts", 16'h0001, 16'(aborts));
		for (int k = 0; k < 200 && rxq.size() > 0; k++)
			@(negedge mclk_i);
		rand_rdy = 1'b0;
		@(posedge mclk_i);
		#1 rx_ready_i = 1'b0;
		for (int k = 0; k < 35; k++)
			frame(16'h0000, 16, k[0]);
		check("overrun", 16'h0001, 16'(ovrs > 0));
		rx_ready_i = 1'b1;
		for (int k = 0; k < 200 && rxq.size() > 0; k++)
			@(negedge mclk_i);
		check("words_left", 16'h0000, 16'(rxq.size()));
		conclude();
	end
endmodule
`default_nettype wire
